// file: include/mas_defs.vh
/*
 Constants for the multiply-accumulate slice: mode codes, lane widths,
 accumulator widths and shift width.
 Assumes it is included by bare name from the design files.
*/
`ifndef MAS_DEFS_VH
`define MAS_DEFS_VH
`define MAS_MODE_SINGLE 2'h0
`define MAS_MODE_DUAL 2'h1
`define MAS_MODE_QUAD 2'h2
`define MAS_MODE_FLOAT 2'h3
`define MAS_OP_ADD 2'h0
`define MAS_OP_SUB 2'h1
`define MAS_OP_ACC 2'h2
`define MAS_OP_BYPASS 2'h3
`define MAS_A_W 19
`define MAS_B_W 18
`define MAS_SUM_W 48
`define MAS_SH_W 4
`define MAS_BF_W 16
`endif

// file: hw/mas_lane.v
/*
 One integer lane: multiplier, optional add/sub/accumulate, right shift.
 Assumes operands are zero-padded above their lane width by the caller.
*/
`include "mas_defs.vh"
module mas_lane #(
   parameter AW = 19,
   parameter BW = 18,
   parameter SW = 48
)(
   input wire clk,
   input wire rstn,
   input wire ce,
   input wire is_signed,
   input wire [1:0] op,
   input wire [AW-1:0] a,
   input wire [BW-1:0] b,
   input wire [SW-1:0] c,
   input wire [3:0] shift,
   output reg [SW-1:0] result_reg
);
   localparam PW = (AW + BW + 2 > SW) ? AW + BW + 2 : SW;
   wire signed [AW:0] a_ext;
   wire signed [BW:0] b_ext;
   wire signed [PW-1:0] a_wide;
   wire signed [PW-1:0] b_wide;
   wire signed [PW-1:0] prod_full;
   wire [SW-1:0] prod;
   reg [SW-1:0] sum_next;

   // Sign extension picks the operand interpretation.
   assign a_ext = {is_signed & a[AW-1], a};
   assign b_ext = {is_signed & b[BW-1], b};
   // Operands are widened first, so a short lane still fills its path.
   assign a_wide = {{(PW-AW-1){a_ext[AW]}}, a_ext};
   assign b_wide = {{(PW-BW-1){b_ext[BW]}}, b_ext};
   assign prod_full = a_wide * b_wide;
   assign prod = prod_full[SW-1:0];

   always @*
   begin
      case (op)
         `MAS_OP_ADD: sum_next = c + prod;
         `MAS_OP_SUB: sum_next = c - prod;
         `MAS_OP_ACC: sum_next = result_reg + prod;
         default: sum_next = prod;
      endcase
   end

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         result_reg <= {SW{1'b0}};
      else if (ce)
      begin
         if (is_signed)
            result_reg <= $signed(sum_next) >>> shift;
         else
            result_reg <= sum_next >> shift;
      end
   end
endmodule

// file: hw/mas_slice.v
/*
 Multiply-accumulate slice: single, dual, quad integer modes and a
 BFLOAT16 fused multiply-add mode.
 Assumes mode and signedness are static settings from configuration.
*/
`include "mas_defs.vh"
// Operation
// - Single mode: one 19x18 product, add or subtract on 48 bits.
// - Dual mode: 11x10 and 8x8 products, each with 24-bit add/sub.
// - Quad mode: one 7x6 and three 4x4 products, four 12-bit paths.
// - Float mode: one fused BFLOAT16 multiply with add/sub/accumulate.
// - Four-bit right shift per lane in every integer mode.
// - Accumulate keeps a running sum over successive operations.
// - Integer multipliers treat operands as signed or unsigned.
// - Product goes out directly or into the add/sub stage.
module mas_slice #(
   parameter [1:0] MODE = `MAS_MODE_SINGLE,
   parameter IS_SIGNED = 1
)(
   input wire clk,
   input wire rstn,
   input wire ce,
   input wire [1:0] op,
   input wire [18:0] a,
   input wire [17:0] b,
   input wire [47:0] c,
   input wire [3:0] shift,
   output reg [47:0] result
);
   ////////////////////////////////////////////////////////////////////////
   // A single signedness wire feeds every lane, so packed lanes share it.
   wire sgn = (IS_SIGNED != 0);
   wire [47:0] r0;
   wire [23:0] d0;
   wire [23:0] d1;
   wire [11:0] q [0:3];
   reg [47:0] fp_reg;
   wire [47:0] lane_out;

   // Operand A feeds the multiplicand port, B the multiplier.
   // Each branch wires only its own operand fields and ignores the rest.
   // Products wider than a lane path are cut to it, so size operands.
   generate
      if (MODE == `MAS_MODE_SINGLE)
      begin : g_single
         mas_lane #(.AW(19), .BW(18), .SW(48)) u0 (
            .clk(clk), .rstn(rstn), .ce(ce), .is_signed(sgn), .op(op),
            .a(a), .b(b), .c(c), .shift(shift), .result_reg(r0)
         );
         assign lane_out = r0;
      end
      else if (MODE == `MAS_MODE_DUAL)
      begin : g_dual
         mas_lane #(.AW(11), .BW(10), .SW(24)) u0 (
            .clk(clk), .rstn(rstn), .ce(ce), .is_signed(sgn), .op(op),
            .a(a[10:0]), .b(b[9:0]), .c(c[23:0]), .shift(shift),
            .result_reg(d0)
         );
         // Lane 1 takes the upper bits, so the two lanes never overlap.
         mas_lane #(.AW(8), .BW(8), .SW(24)) u1 (
            .clk(clk), .rstn(rstn), .ce(ce), .is_signed(sgn), .op(op),
            .a(a[18:11]), .b(b[17:10]), .c(c[47:24]), .shift(shift),
            .result_reg(d1)
         );
         assign lane_out = {d1, d0};
      end
      else if (MODE == `MAS_MODE_QUAD)
      begin : g_quad
         genvar i;
         mas_lane #(.AW(7), .BW(6), .SW(12)) u0 (
            .clk(clk), .rstn(rstn), .ce(ce), .is_signed(sgn), .op(op),
            .a(a[6:0]), .b(b[5:0]), .c(c[11:0]), .shift(shift),
            .result_reg(q[0])
         );
         for (i = 1; i < 4; i = i + 1)
         begin : g_small
            // Small lanes pack above lane 0 with no gap or overlap.
            localparam AL = 4 * i + 3;
            localparam BL = 4 * i + 2;
            mas_lane #(.AW(4), .BW(4), .SW(12)) u (
               .clk(clk), .rstn(rstn), .ce(ce), .is_signed(sgn), .op(op),
               .a(a[AL+3:AL]), .b(b[BL+3:BL]),
               .c(c[11+12*i:12*i]), .shift(shift), .result_reg(q[i])
            );
         end
         assign lane_out = {q[3], q[2], q[1], q[0]};
      end
      else
      begin : g_float
         assign lane_out = fp_reg;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Float path: bfloat16 in a[15:0], b[15:0], addend c[15:0].
   // Denormal multiplier inputs flush to zero; truncation rounding keeps the adder small.
   // Infinity and NaN both saturate to infinity, since the slice has no
   // status output that could report an invalid operation.
   function bf_top_exp;
      input [15:0] x;
      begin
         bf_top_exp = (x[14:7] == 8'hFF);
      end
   endfunction

   function bf_zero_exp;
      input [15:0] x;
      begin
         bf_zero_exp = (x[14:7] == 8'h00);
      end
   endfunction

   function [15:0] bf_mul;
      input [15:0] x;
      input [15:0] y;
      reg [15:0] m;
      reg [9:0] e;
      reg sg;
      begin
         sg = x[15] ^ y[15];
         m = {8'h00, 1'b1, x[6:0]} * {8'h00, 1'b1, y[6:0]};
         e = {2'h0, x[14:7]} + {2'h0, y[14:7]} - 10'h07F;
         if (m[15])
         begin
            m = m >> 1;
            e = e + 10'h001;
         end
         if (bf_top_exp(x) || bf_top_exp(y))
            bf_mul = {sg, 8'hFF, 7'h00};
         else if (bf_zero_exp(x) || bf_zero_exp(y) || e[9])
            bf_mul = {sg, 15'h0000};
         else if (e[8:0] == 9'h000)
            bf_mul = {sg, 15'h0000};
         else if (e[8] || e[7:0] == 8'hFF)
            bf_mul = {sg, 8'hFF, 7'h00};
         else
            bf_mul = {sg, e[7:0], m[13:7]};
      end
   endfunction

   function [15:0] bf_add;
      input [15:0] x;
      input [15:0] y;
      reg [15:0] big;
      reg [15:0] sml;
      reg [9:0] mb;
      reg [9:0] ms;
      reg [9:0] s;
      reg [7:0] e;
      reg [7:0] d;
      integer k;
      begin
         if (x[14:0] >= y[14:0])
         begin
            big = x;
            sml = y;
         end
         else
         begin
            big = y;
            sml = x;
         end
         e = big[14:7];
         d = big[14:7] - sml[14:7];
         mb = {2'h0, !bf_zero_exp(big), big[6:0]};
         ms = {2'h0, !bf_zero_exp(sml), sml[6:0]};
         ms = (d > 8'h09) ? 10'h000 : (ms >> d);
         s = (big[15] == sml[15]) ? mb + ms : mb - ms;
         if (s[8])
         begin
            s = s >> 1;
            e = e + 8'h01;
         end
         for (k = 0; k < 8; k = k + 1)
            if (!s[7] && s != 10'h000 && e > 8'h01)
            begin
               s = s << 1;
               e = e - 8'h01;
            end
         if (bf_top_exp(big) || e == 8'hFF)
            bf_add = {big[15], 8'hFF, 7'h00};
         else if (s == 10'h000 || bf_zero_exp(big))
            bf_add = bf_zero_exp(big) ? sml : 16'h0000;
         else
            bf_add = {big[15], e, s[6:0]};
      end
   endfunction

   wire [15:0] fp_prod = bf_mul(a[15:0], b[15:0]);
   reg [15:0] fp_next;

   always @*
   begin
      case (op)
         `MAS_OP_ADD: fp_next = bf_add(c[15:0], fp_prod);
         `MAS_OP_SUB: fp_next = bf_add(c[15:0], fp_prod ^ 16'h8000);
         `MAS_OP_ACC: fp_next = bf_add(fp_reg[15:0], fp_prod);
         default: fp_next = fp_prod;
      endcase
   end

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         fp_reg <= 48'h000000000000;
      else if (ce && MODE == `MAS_MODE_FLOAT)
         fp_reg <= {32'h00000000, fp_next};
   end

   ////////////////////////////////////////////////////////////////////////
   // Output register keeps the top-level output straight from a flop.
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         result <= 48'h000000000000;
      else if (ce)
         result <= lane_out;
   end
endmodule

// file: dv/mas_slice_properties.sv
/*
 Port assertions for the slice in single mode, plus an idle hold check that applies in every mode.
 Assumes one clock and an active-low asynchronous reset.
*/
`include "mas_defs.vh"
module mas_slice_props #(
   parameter [1:0] MODE = `MAS_MODE_SINGLE,
   parameter IS_SIGNED = 1
)(
   input wire clk,
   input wire rstn,
   input wire ce,
   input wire [1:0] op,
   input wire [18:0] a,
   input wire [17:0] b,
   input wire [47:0] c,
   input wire [3:0] shift,
   input wire [47:0] result
);
   timeunit 1ns;
   timeprecision 1ns;
   wire one = (MODE == `MAS_MODE_SINGLE);
   wire by = one && ce && op == `MAS_OP_BYPASS;
   wire signed [47:0] ps = $signed(a) * $signed(b);
   wire [47:0] p = IS_SIGNED ? ps : {29'h0, a} * {30'h0, b};
   // The cast keeps the shift arithmetic despite the unsigned branch.
   wire [47:0] psh = IS_SIGNED ? $unsigned(ps >>> shift) : p >> shift;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////////
   a_hold_when_idle: assert property (!ce |=> $stable(result))
      else $error("result moved while idle");
   a_product_out: assert property (
      by && shift == 4'h0 ##1 ce |=> result == $past(p, 2))
      else $error("product wrong");
   a_add_path: assert property (
      one && ce && op == `MAS_OP_ADD && shift == 4'h0 ##1 ce
      |=> result == $past(c, 2) + $past(p, 2))
      else $error("sum wrong");
   a_sub_path: assert property (
      one && ce && op == `MAS_OP_SUB && shift == 4'h0 ##1 ce
      |=> result == $past(c, 2) - $past(p, 2))
      else $error("difference wrong");
   a_shift_right: assert property (
      by && shift != 4'h0 ##1 ce |=> result == $past(psh, 2))
      else $error("shift wrong");
   a_running_sum: assert property (
      one && ce && op == `MAS_OP_ACC && shift == 4'h0 ##1 ce
      |=> result == $past(result, 1) + $past(p, 2))
      else $error("accumulation wrong");
   a_zero_operand: assert property (
      by && (a == 19'h0 || b == 18'h0) ##1 ce |=> result == 48'h0)
      else $error("zero product wrong");
   a_sign_kept: assert property (
      by && shift == 4'h0 && a[18] && !b[17] && b != 18'h0 ##1 ce
      |=> result[47] == (IS_SIGNED != 0))
      else $error("sign wrong");
endmodule
bind mas_slice mas_slice_props #(.MODE(MODE), .IS_SIGNED(IS_SIGNED)) u_props (
   .clk(clk), .rstn(rstn), .ce(ce), .op(op), .a(a), .b(b), .c(c),
   .shift(shift), .result(result));

// file: dv/mas_fabric.sv
/*
 Fabric user logic presenting operands to the slice.
 Assumes the bench calls issue once per clock.
*/
module mas_fabric (
   input wire clk,
   output logic ce = 1'b0,
   output logic [1:0] op = 2'h0,
   output logic [18:0] a = 19'h0,
   output logic [17:0] b = 18'h0,
   output logic [47:0] c = 48'h0,
   output logic [3:0] shift = 4'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   // One model instance drives the same operand buses into every slice.
   task automatic issue(input logic [1:0] o, input logic [18:0] x,
      input logic [17:0] y, input logic [47:0] z, input logic [3:0] s,
      input logic en);
      @(posedge clk);
      #5;
      ce = en;
      op = o;
      a = x;
      b = y;
      c = z;
      shift = s;
   endtask
endmodule

// file: dv/mas_slice_tb.sv
/*
 Self-checking bench for the slice in all four modes.
 Assumes the fabric model drives operands and the checker is bound.
*/
`include "mas_defs.vh"
module mas_slice_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   wire ce;
   wire [1:0] op;
   wire [18:0] a;
   wire [17:0] b;
   wire [47:0] c;
   wire [3:0] shift;
   wire [47:0] result;
   wire [47:0] res_dual;
   wire [47:0] res_quad;
   wire [47:0] res_flt;
   int mismatches = 0;
   int samples_checked = 0;
   always #25 clk = ~clk;
   mas_fabric fab (.clk(clk), .ce(ce), .op(op), .a(a), .b(b), .c(c),
      .shift(shift));
   mas_slice #(.MODE(`MAS_MODE_SINGLE), .IS_SIGNED(1)) uut (.clk(clk),
      .rstn(rstn), .ce(ce), .op(op), .a(a), .b(b), .c(c), .shift(shift),
      .result(result));
   // The other modes share the same operand buses; quad runs unsigned.
   mas_slice #(.MODE(`MAS_MODE_DUAL), .IS_SIGNED(1)) uut_dual (.clk(clk),
      .rstn(rstn), .ce(ce), .op(op), .a(a), .b(b), .c(c), .shift(shift),
      .result(res_dual));
   mas_slice #(.MODE(`MAS_MODE_QUAD), .IS_SIGNED(0)) uut_quad (.clk(clk),
      .rstn(rstn), .ce(ce), .op(op), .a(a), .b(b), .c(c), .shift(shift),
      .result(res_quad));
   mas_slice #(.MODE(`MAS_MODE_FLOAT), .IS_SIGNED(1)) uut_flt (.clk(clk),
      .rstn(rstn), .ce(ce), .op(op), .a(a), .b(b), .c(c), .shift(shift),
      .result(res_flt));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [47:0] got, e);
      samples_checked++;
      if (got !== e)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, got);
      end
   endtask
   task automatic close_out();
      if (mismatches == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Two taken edges move the operation through both stages.
   task automatic run2(input logic [1:0] o, input logic [18:0] x,
      input logic [17:0] y, input logic [47:0] z, input logic [3:0] s);
      fab.issue(o, x, y, z, s, 1'b1);
      fab.issue(o, x, y, z, s, 1'b1);
      fab.issue(o, x, y, z, s, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_ops();
      logic [1:0] o;
      logic [3:0] s;
      logic [18:0] x;
      logic signed [47:0] r;
      for (int i = 0; i < 6; i++)
      begin
         o = (i % 3 == 2) ? `MAS_OP_BYPASS : 2'(i % 3);
         s = (i < 3) ? 4'h0 : 4'(4 * i - 5);
         x = 19'h7FF00 + 19'(i);
         run2(o, x, 18'h00321, 48'h00000ABC0000, s);
         r = $signed(x) * $signed(18'h00321);
         if (o == `MAS_OP_ADD)
            r = 48'sh00000ABC0000 + r;
         if (o == `MAS_OP_SUB)
            r = 48'sh00000ABC0000 - r;
         check("op", result, r >>> s);
      end
   endtask
   task automatic t_acc();
      fab.issue(`MAS_OP_BYPASS, 19'h00100, 18'h00020, 48'h0, 4'h0, 1'b1);
      fab.issue(`MAS_OP_ACC, 19'h7FFF0, 18'h00003, 48'h0, 4'h0, 1'b1);
      fab.issue(`MAS_OP_BYPASS, 19'h0, 18'h0, 48'h0, 4'h0, 1'b1);
      fab.issue(`MAS_OP_BYPASS, 19'h0, 18'h0, 48'h0, 4'h0, 1'b0);
      check("sum", result, 48'h1FD0);
   endtask
   task automatic t_stall();
      run2(`MAS_OP_BYPASS, 19'h12345, 18'h0, 48'h0, 4'h2);
      check("zero", result, 48'h0);
      run2(`MAS_OP_BYPASS, 19'h00005, 18'h00007, 48'h0, 4'h0);
      repeat (3) fab.issue(`MAS_OP_ADD, 19'h1, 18'h1, 48'h5, 4'h0, 1'b0);
      check("held", result, 48'h23);
      fab.issue(`MAS_OP_ACC, 19'h1, 18'h1, 48'h0, 4'h0, 1'b1);
      fab.issue(`MAS_OP_ACC, 19'h0, 18'h0, 48'h0, 4'h0, 1'b1);
      fab.issue(`MAS_OP_BYPASS, 19'h0, 18'h0, 48'h0, 4'h0, 1'b0);
      check("resume", result, 48'h24);
   endtask
   task automatic t_modes();
      run2(`MAS_OP_ADD, 19'h02FFF, 18'h01803, 48'h000100000010, 4'h1);
      check("dual", res_dual, 48'h00008F000006);
      run2(`MAS_OP_BYPASS, 19'h49FFF, 18'h097C3, 48'h0, 4'h2);
      check("quad", res_quad, 48'h00400303805F);
      fab.issue(`MAS_OP_ADD, 19'h03FC0, 18'h04000, 48'h3F80, 4'h0, 1'b1);
      fab.issue(`MAS_OP_ACC, 19'h03FC0, 18'h04000, 48'h0, 4'h0, 1'b1);
      fab.issue(`MAS_OP_BYPASS, 19'h0, 18'h0, 48'h0, 4'h0, 1'b1);
      check("float sum", res_flt, 48'h4080);
      fab.issue(`MAS_OP_BYPASS, 19'h0, 18'h0, 48'h0, 4'h0, 1'b0);
      check("float acc", res_flt, 48'h40E0);
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      #5 rstn = 1'b1;
      check("reset", result, 48'h0);
      t_ops();
      t_acc();
      t_stall();
      t_modes();
      close_out();
   end
   initial
   begin
      #50000;
      mismatches++;
      close_out();
   end
endmodule
